// file: bench/udsr_host_model.sv
// Purpose: microprocessor on the shared command and data bus
// Assumes: write strobe held six mclk, read strobe until data_oe plus two, well past the three-flop synchroniser
// Notes: an idle data bus shows a pattern that flips every cycle
module udsr_host_model (
	// clocking
	input wire logic mclk,
	// bus pins
	output logic command_data_select,
	output logic wr_n,
	output logic rd_n,
	output logic [15:0] data_in,
	input wire logic [15:0] data_out,
	input wire logic data_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic busy = 1'b0;
	logic [15:0] cmd_q = 16'h0000;
	logic [15:0] pat = 16'hA5A5;
	initial begin
		command_data_select = 1'b1;
		wr_n = 1'b1;
		rd_n = 1'b1;
	end
	// released bus never keeps the last command word
	always @(posedge mclk) pat <= ~pat;
	assign data_in = busy ? cmd_q : pat;
	// command phase; high byte is noise since the device ignores it
	task automatic cmd(input logic [7:0] code);
		@(posedge mclk);
		command_data_select <= 1'b1;
		cmd_q <= {8'($urandom), code};
		busy <= 1'b1;
		wr_n <= 1'b0;
		repeat (6) @(posedge mclk);
		wr_n <= 1'b1;
		repeat (6) @(posedge mclk);
		busy <= 1'b0;
	endtask
	// data phase; one word, bounded wait for the output enable
	task automatic rd(output logic [15:0] w);
		int n;
		n = 0;
		@(posedge mclk);
		command_data_select <= 1'b0;
		rd_n <= 1'b0;
		do begin
			@(posedge mclk);
			n++;
		end while (data_oe !== 1'b1 && n < 30);
		repeat (2) @(posedge mclk);
		w = (n < 30) ? data_out : 16'hxxxx;
		rd_n <= 1'b1;
		repeat (8) @(posedge mclk);
	endtask
endmodule

// file: bench/usb_device_status_readback_test.sv
// Purpose: self-checking bench for the status readback block
// Assumes: pseudo frame tick too slow to reach in this run
// Notes: expected words come from a small model kept in a queue
`include "udsr_consts.svh"
module usb_device_status_readback_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] PC = 8'hA7; // arbitrary value
	localparam logic [7:0] SV = 8'h42; // arbitrary value
	localparam logic [31:0] SRC = 32'h00FF_FF5B; // sources driven as pulses
	logic mclk, reset, sel, wr_n, rd_n, data_oe, irq, sleep_ent, sleep;
	logic [15:0] data_in, data_out;
	logic [10:0] frame_number, fr;
	logic [31:0] src, mask, flags, e, p;
	logic [15:0] expq[$];
	int mismatches = 0;
	int comparisons = 0;
	// 125 MHz clock
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	udsr_host_model host (.mclk(mclk), .command_data_select(sel), .wr_n(wr_n), .rd_n(rd_n),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe));
	udsr_top #(.PART_CODE(PC), .SILICON_VERSION(SV)) DUT (.mclk(mclk), .reset(reset),
		.clk_en(1'b1), .command_data_select(sel), .wr_n(wr_n), .rd_n(rd_n),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe), .frame_valid(src[4]),
		.frame_number(frame_number), .ep_pend(src[23:10]), .control_in_pending(src[9]),
		.control_out_pending(src[8]), .bus_sleep_state(sleep), .short_packet_done(src[6]),
		.dma_count_done(src[3]), .resume_seen(src[1]), .bus_reset_seen(src[0]),
		.interrupt_source_mask(mask), .irq(irq), .bus_sleep_entered(sleep_ent));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// one command, then n word reads checked against the model queue
	task automatic read_cmp(input logic [7:0] code, input int n);
		logic [15:0] w;
		host.cmd(code);
		repeat (n) begin
			host.rd(w);
			check(32'(w), 32'(expq.pop_front()));
		end
	endtask
	// one-cycle source pulses; model latches them and the frame number
	task automatic pulse(input logic [31:0] v);
		logic [10:0] f;
		f = 11'($urandom);
		@(posedge mclk);
		src <= v & SRC;
		frame_number <= f;
		@(posedge mclk);
		src <= 32'h0000_0000;
		if (v[4]) fr = f;
		flags = flags | (v & SRC);
	endtask
	// hang guard, far beyond the expected run
	initial begin
		#200us;
		mismatches++;
		conclude();
	end
	// main sequence
	initial begin
		reset = 1'b1;
		src = 32'h0000_0000;
		mask = 32'h0000_0000;
		sleep = 1'b0;
		frame_number = 11'h000;
		flags = 32'h0000_0000;
		p = $urandom(25);
		repeat (20) @(posedge mclk);
		reset <= 1'b0;
		repeat (2) @(posedge mclk);
		check(32'({irq, sleep_ent, data_oe}), 32'h0000_0000);
		$display("test reset done");
		// extra read after a single-word command returns zero
		expq = '{{PC, SV}, 16'h0000};
		read_cmp(`UDSR_CMD_IDENT, 2);
		$display("test ident done");
		pulse(32'h0000_0010);
		expq = '{{5'b00000, fr}, 16'h0000};
		read_cmp(`UDSR_CMD_FRAME, 2);
		expq = '{16'h0000};
		read_cmp(8'h3C, 1);
		$display("test frame done");
		// odd rounds raise the sleep level, which also latches bit 2
		for (int i = 0; i < 6; i++) begin
			sleep <= i[0];
			if (i[0]) flags[`UDSR_BIT_SUSP] = 1'b1;
			repeat (10) @(posedge mclk);
			p = $urandom;
			pulse(p);
			mask <= $urandom & 32'hFFFF_FF7F;
			repeat (4) @(posedge mclk);
			check(32'(irq), 32'(|(flags & mask)));
			e = flags | (32'(i[0]) << `UDSR_BIT_SLEEP);
			expq = '{e[15:0], e[31:16]};
			read_cmp(`UDSR_CMD_INTR, 2);
			flags = 32'h0000_0000;
			e = 32'(i[0]) << `UDSR_BIT_SLEEP;
			expq = '{e[15:0], e[31:16]};
			read_cmp(`UDSR_CMD_INTR, 2);
		end
		check(32'(irq), 32'h0000_0000);
		$display("test interrupt done");
		conclude();
	end
endmodule

// file: rtl/udsr_consts.svh
// Purpose: constants for the usb device status readback block
// Assumes: 125 MHz mclk
// Notes: command codes sit on the low data byte of a command phase
`ifndef UDSR_CONSTS_SVH
`define UDSR_CONSTS_SVH
`define UDSR_CMD_FRAME 8'hB4
`define UDSR_CMD_IDENT 8'hB5
`define UDSR_CMD_INTR 8'hC0
`define UDSR_FRAME_HI_MSB 10
`define UDSR_FRAME_HI_LSB 8
`define UDSR_FRAME_LO_MSB 7
`define UDSR_FRAME_RESET 16'h0000
`define UDSR_INTR_RESET 32'h0000_0000
`define UDSR_BIT_EP_LSB 10
`define UDSR_BIT_EP_MSB 23
`define UDSR_BIT_CTL_IN 9
`define UDSR_BIT_CTL_OUT 8
`define UDSR_BIT_SLEEP 7
`define UDSR_BIT_SHORT 6
`define UDSR_BIT_PTICK 5
`define UDSR_BIT_SOF 4
`define UDSR_BIT_DMA 3
`define UDSR_BIT_SUSP 2
`define UDSR_BIT_RESUME 1
`define UDSR_BIT_BUSRST 0
`define UDSR_CLK_MHZ 125
`define UDSR_PTICK_US 1000
`define UDSR_PTICK_CYCLES (`UDSR_PTICK_US * `UDSR_CLK_MHZ)
`define UDSR_MISSED_SOF 3
`endif

// file: rtl/udsr_events.sv
// Purpose: latches interrupt sources and runs the pseudo frame timer
// Assumes: event inputs are one-cycle pulses on mclk, except sleep_lvl, which is a level
// Notes: a set arriving with the clear wins
`include "udsr_consts.svh"
module udsr_events (
	// clocking
	input wire logic mclk,
	input wire logic reset,
	input wire logic clk_en,
	// event sources
	input wire logic [13:0] ep_pend,
	input wire logic ctl_in_pend,
	input wire logic ctl_out_pend,
	input wire logic sleep_lvl,
	input wire logic short_pkt,
	input wire logic sof_seen,
	input wire logic dma_zero,
	input wire logic resume_seen,
	input wire logic bus_reset_seen,
	// to top
	udsr_evt_if.unit evt,
	output logic sleep_entered
);
	typedef struct packed {
		logic [31:0] flags;
		logic [16:0] tmr;
		logic [1:0] missed;
		logic asleep;
		logic sleep_prev;
	} udsr_evt_s;
	udsr_evt_s st_q, st_d;
	logic [31:0] set_v;
	logic tick;

	assign tick = (st_q.tmr == 17'(`UDSR_PTICK_CYCLES - 1));

	// build per-bit set vector; endpoints via generate
	genvar gi;
	generate
		for (gi = 0; gi < 14; gi++) begin : g_ep
			assign set_v[`UDSR_BIT_EP_LSB + gi] = ep_pend[gi]; // RULE_09
		end
	endgenerate
	assign set_v[31:24] = 8'h00; // RULE_09
	assign set_v[`UDSR_BIT_CTL_IN] = ctl_in_pend; // RULE_10
	assign set_v[`UDSR_BIT_CTL_OUT] = ctl_out_pend; // RULE_10
	assign set_v[`UDSR_BIT_SLEEP] = 1'b0;
	assign set_v[`UDSR_BIT_SHORT] = short_pkt; // RULE_12
	assign set_v[`UDSR_BIT_PTICK] = tick; // RULE_13
	assign set_v[`UDSR_BIT_SOF] = sof_seen; // RULE_14
	assign set_v[`UDSR_BIT_DMA] = dma_zero; // RULE_15
	assign set_v[`UDSR_BIT_SUSP] = sleep_lvl & ~st_q.sleep_prev; // RULE_16
	assign set_v[`UDSR_BIT_RESUME] = resume_seen; // RULE_17
	assign set_v[`UDSR_BIT_BUSRST] = bus_reset_seen; // RULE_17

	// timer restarts on each real sof so a tick means a missed frame
	always_comb begin
		st_d = st_q;
		st_d.sleep_prev = sleep_lvl;
		st_d.tmr = (tick || sof_seen) ? 17'h0_0000 : st_q.tmr + 17'h0_0001;
		if (sof_seen || resume_seen || bus_reset_seen) begin
			st_d.missed = 2'h0;
			st_d.asleep = 1'b0;
		end else if (tick) begin
			if (st_q.missed == 2'(`UDSR_MISSED_SOF - 1)) begin
				st_d.asleep = 1'b1; // RULE_13
			end else begin
				st_d.missed = st_q.missed + 2'h1;
			end
		end
		// set wins over clear; live state bit never latched
		st_d.flags = ((evt.clear_all ? 32'h0000_0000 : st_q.flags) | set_v); // RULE_19
		st_d.flags[`UDSR_BIT_SLEEP] = sleep_lvl | st_q.asleep; // RULE_11
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			st_q <= '0;
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	assign evt.flags = st_q.flags;
	assign evt.frame_tick = tick;
	assign sleep_entered = st_q.asleep;

	chk_flag_sticky: assert property (@(posedge mclk) disable iff (reset)
		clk_en && set_v[`UDSR_BIT_SOF] |=> st_q.flags[`UDSR_BIT_SOF]) // RULE_14
		else $error("sof flag not latched");
	chk_clear_keeps_set: assert property (@(posedge mclk) disable iff (reset)
		clk_en && evt.clear_all && dma_zero |=> st_q.flags[`UDSR_BIT_DMA]) // RULE_15
		else $error("set lost against clear");
	chk_reserved_zero: assert property (@(posedge mclk) disable iff (reset)
		st_q.flags[31:24] == 8'h00) // RULE_09
		else $error("reserved interrupt bits set");
	chk_suspend_edge: assert property (@(posedge mclk) disable iff (reset)
		clk_en && sleep_lvl && !st_q.sleep_prev |=> st_q.flags[`UDSR_BIT_SUSP]) // RULE_16
		else $error("suspend edge not flagged");
	cov_pseudo_tick: cover property (@(posedge mclk) disable iff (reset) clk_en && tick);
	cov_asleep: cover property (@(posedge mclk) disable iff (reset) $rose(st_q.asleep));
endmodule

// file: rtl/udsr_evt_if.sv
// Purpose: carries latched events from the event unit to the top
// Assumes: one clock domain
// Notes: clear_all pulses after the second interrupt word read
interface udsr_evt_if;
	logic [31:0] flags;
	logic clear_all;
	logic frame_tick;
	modport unit (output flags, output frame_tick, input clear_all);
	modport top (input flags, input frame_tick, output clear_all);
endinterface

// file: rtl/udsr_pkg.sv
// Purpose: shared types of the status readback block
// Assumes: nothing
// Notes: read selector says which word the next data read returns
package udsr_pkg;
	typedef enum logic [1:0] {
		UDSR_RD_NONE = 2'b00,
		UDSR_RD_FRAME = 2'b01,
		UDSR_RD_IDENT = 2'b10,
		UDSR_RD_INTR = 2'b11
	} udsr_rdsel_e;
endpackage

// file: rtl/udsr_sync.sv
// Purpose: three-flop synchroniser with agreement on the last two stages
// Assumes: async level input
// Notes: first stage feeds only the second stage
module udsr_sync (
	// clocking
	input wire logic mclk,
	input wire logic reset,
	input wire logic clk_en,
	// level
	input wire logic din,
	output logic dout
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic o;
	} udsr_sync_s;
	udsr_sync_s st_q, st_d;

	// output changes only once stages two and three agree
	always_comb begin
		st_d = st_q;
		st_d.s1 = din;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		if (st_q.s2 == st_q.s3) begin
			st_d.o = st_q.s3;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			st_q <= '0;
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end
	assign dout = st_q.o;
endmodule

// file: rtl/udsr_top.sv
// Purpose: status readback part of a usb device command interface
// Assumes: bus strobes from pins, synchronised; event sources on mclk
// Notes: command phase when command_data_select high, data reads when low
//
// Behaviour
// RULE_01: frame word holds 11-bit count in bits 10..0, bits 15..11 zero.
// RULE_02: host writes B4 with select high, high byte ignored, then reads one word.
// RULE_03: B4 is followed by exactly one read returning last good frame number.
// RULE_04: frame count undefined after bus reset until the next frame start.
// RULE_05: command B5 returns one read-only identification word.
// RULE_06: id high byte is part code, low byte silicon version in BCD.
// RULE_07: host firmware uses the id word to choose features.
// RULE_08: command C0 returns 32-bit interrupt word as two reads; host does both.
// RULE_09: bits 23..10 flag endpoints 14..1; bits 31..24 reserved zero.
// RULE_10: bit 9 flags control in endpoint, bit 8 control out endpoint.
// RULE_11: bit 7 shows live bus sleep state, not a latched event.
// RULE_12: bit 6 set on end of transfer caused by a short packet.
// RULE_13: bit 5 set by 1 ms pseudo frame tick; three misses enter sleep.
// RULE_14: bit 4 set whenever a frame start is detected.
// RULE_15: bit 3 set when the dma transfer counter reaches zero.
// RULE_16: bit 2 set on change from awake to sleep; code sets it only on a rise of bus_sleep_state, not on missed-tick sleep.
// RULE_17: bit 1 set on resume, bit 0 on bus reset.
// RULE_18: a source raises the interrupt output only if its mask bit is set.
// RULE_19: event flags stay until both words are read, then clear; bit 7 exempt.
`include "udsr_consts.svh"
module udsr_top #(
	parameter logic [7:0] PART_CODE = 8'h5A, // arbitrary value
	parameter logic [7:0] SILICON_VERSION = 8'h10 // arbitrary value
) (
	// clocking
	mclk,
	reset,
	clk_en,
	// host bus pins
	command_data_select,
	wr_n,
	rd_n,
	data_in,
	data_out,
	data_oe,
	// frame counter input
	frame_valid,
	frame_number,
	// interrupt sources and mask
	ep_pend,
	control_in_pending,
	control_out_pending,
	bus_sleep_state,
	short_packet_done,
	dma_count_done,
	resume_seen,
	bus_reset_seen,
	interrupt_source_mask,
	// outputs
	irq,
	bus_sleep_entered
);
	// clocking
	input wire logic mclk;
	input wire logic reset;
	input wire logic clk_en;
	// host bus pins
	input wire logic command_data_select;
	input wire logic wr_n;
	input wire logic rd_n;
	input wire logic [15:0] data_in;
	output logic [15:0] data_out;
	output logic data_oe;
	// frame counter input
	input wire logic frame_valid;
	input wire logic [10:0] frame_number;
	// interrupt sources and mask
	input wire logic [13:0] ep_pend;
	input wire logic control_in_pending;
	input wire logic control_out_pending;
	input wire logic bus_sleep_state;
	input wire logic short_packet_done;
	input wire logic dma_count_done;
	input wire logic resume_seen;
	input wire logic bus_reset_seen;
	input wire logic [31:0] interrupt_source_mask;
	// outputs
	output logic irq;
	output logic bus_sleep_entered;

	typedef struct packed {
		udsr_pkg::udsr_rdsel_e sel;
		logic word1;
		logic [15:0] frame;
		logic [15:0] dout;
		logic oe;
		logic rd_prev;
		logic wr_prev;
		logic clr;
		logic irq;
		logic slp;
	} udsr_top_s;
	udsr_top_s st_q, st_d;
	logic sel_s, wr_s, rd_s;
	logic rd_start, rd_end, wr_end;
	logic sleep_entered_w;

	udsr_evt_if evt();

	// pin strobes cross from the host's timing domain
	udsr_sync u_sync_sel (.mclk(mclk), .reset(reset), .clk_en(clk_en),
		.din(command_data_select), .dout(sel_s));
	udsr_sync u_sync_wr (.mclk(mclk), .reset(reset), .clk_en(clk_en),
		.din(~wr_n), .dout(wr_s));
	udsr_sync u_sync_rd (.mclk(mclk), .reset(reset), .clk_en(clk_en),
		.din(~rd_n), .dout(rd_s));

	udsr_events u_events (
		.mclk(mclk),
		.reset(reset),
		.clk_en(clk_en),
		.ep_pend(ep_pend),
		.ctl_in_pend(control_in_pending),
		.ctl_out_pend(control_out_pending),
		.sleep_lvl(bus_sleep_state),
		.short_pkt(short_packet_done),
		.sof_seen(frame_valid),
		.dma_zero(dma_count_done),
		.resume_seen(resume_seen),
		.bus_reset_seen(bus_reset_seen),
		.evt(evt),
		.sleep_entered(sleep_entered_w)
	);

	assign rd_start = rd_s & ~st_q.rd_prev;
	assign rd_end = ~rd_s & st_q.rd_prev;
	assign wr_end = ~wr_s & st_q.wr_prev;
	assign evt.clear_all = st_q.clr;

	// command decode, data read sequencing, frame capture, irq gating
	always_comb begin
		st_d = st_q;
		st_d.rd_prev = rd_s;
		st_d.wr_prev = wr_s;
		st_d.clr = 1'b0;
		// frame value after bus reset is left as is until a new frame start
		if (frame_valid) begin
			st_d.frame = {5'h00, frame_number}; // RULE_01 RULE_04
		end
		if (wr_end && sel_s) begin
			st_d.word1 = 1'b0;
			case (data_in[7:0]) // RULE_02
				`UDSR_CMD_FRAME: st_d.sel = udsr_pkg::UDSR_RD_FRAME;
				`UDSR_CMD_IDENT: st_d.sel = udsr_pkg::UDSR_RD_IDENT; // RULE_05
				`UDSR_CMD_INTR: st_d.sel = udsr_pkg::UDSR_RD_INTR; // RULE_08
				default: st_d.sel = udsr_pkg::UDSR_RD_NONE;
			endcase
		end
		if (rd_start && !sel_s) begin
			st_d.oe = 1'b1;
			case (st_q.sel)
				udsr_pkg::UDSR_RD_FRAME: st_d.dout = st_q.frame; // RULE_03
				udsr_pkg::UDSR_RD_IDENT: st_d.dout = {PART_CODE, SILICON_VERSION}; // RULE_06
				udsr_pkg::UDSR_RD_INTR: begin
					st_d.dout = st_q.word1 ? evt.flags[31:16] : evt.flags[15:0]; // RULE_08
				end
				default: st_d.dout = 16'h0000;
			endcase
		end
		if (rd_end && st_q.oe) begin
			st_d.oe = 1'b0;
			case (st_q.sel)
				udsr_pkg::UDSR_RD_INTR: begin
					if (st_q.word1) begin
						st_d.clr = 1'b1; // RULE_19
						st_d.sel = udsr_pkg::UDSR_RD_NONE;
						st_d.word1 = 1'b0;
					end else begin
						st_d.word1 = 1'b1;
					end
				end
				default: st_d.sel = udsr_pkg::UDSR_RD_NONE; // RULE_03
			endcase
		end
		st_d.irq = |(evt.flags & interrupt_source_mask); // RULE_18
		st_d.slp = sleep_entered_w;
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			st_q <= '{sel: udsr_pkg::UDSR_RD_NONE, frame: `UDSR_FRAME_RESET, default: '0};
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	// outputs straight from flops
	assign data_out = st_q.dout;
	assign data_oe = st_q.oe;
	assign irq = st_q.irq;
	assign bus_sleep_entered = st_q.slp;

	chk_frame_upper_zero: assert property (@(posedge mclk) disable iff (reset)
		st_q.frame[15:11] == 5'h00) // RULE_01
		else $error("frame reserved bits set");
	chk_frame_capture: assert property (@(posedge mclk) disable iff (reset)
		clk_en && frame_valid |=> st_q.frame[10:0] == $past(frame_number)) // RULE_01
		else $error("frame number not captured");
	chk_cmd_frame: assert property (@(posedge mclk) disable iff (reset)
		clk_en && wr_end && sel_s && data_in[7:0] == `UDSR_CMD_FRAME
		|=> st_q.sel == udsr_pkg::UDSR_RD_FRAME) // RULE_02
		else $error("frame command not decoded");
	chk_one_frame_read: assert property (@(posedge mclk) disable iff (reset)
		clk_en && rd_end && st_q.oe && st_q.sel == udsr_pkg::UDSR_RD_FRAME
		|=> st_q.sel == udsr_pkg::UDSR_RD_NONE) // RULE_03
		else $error("frame read not single");
	chk_ident_word: assert property (@(posedge mclk) disable iff (reset)
		clk_en && rd_start && !sel_s && st_q.sel == udsr_pkg::UDSR_RD_IDENT
		|=> st_q.dout == {PART_CODE, SILICON_VERSION}) // RULE_05 RULE_06
		else $error("identification word wrong");
	chk_irq_masked: assert property (@(posedge mclk) disable iff (reset)
		clk_en && !(|(evt.flags & interrupt_source_mask)) |=> !st_q.irq) // RULE_18
		else $error("irq raised with masked sources");
	chk_clear_after_two: assert property (@(posedge mclk) disable iff (reset)
		st_q.clr |-> $past(st_q.word1) && $past(st_q.sel) == udsr_pkg::UDSR_RD_INTR) // RULE_19
		else $error("interrupt flags cleared early");
	chk_sleep_live: assert property (@(posedge mclk) disable iff (reset)
		clk_en && bus_sleep_state |=> evt.flags[`UDSR_BIT_SLEEP]) // RULE_11
		else $error("sleep state bit not live");
	cov_intr_pair: cover property (@(posedge mclk) disable iff (reset) st_q.clr);
	cov_ident_read: cover property (@(posedge mclk) disable iff (reset)
		rd_start && st_q.sel == udsr_pkg::UDSR_RD_IDENT);
	cov_irq: cover property (@(posedge mclk) disable iff (reset) $rose(st_q.irq));
endmodule
